// [fan_loop_pkg.sv]
// Notes on behaviour
// - Loop enable bit 7 selects automatic drive
// - Range bits 6:5 weight all tach values
// - Range codes give 500..4000 RPM, x1..x8
// - Edges bits 4:3 give 3,5,7,9 edges
// - Edge mismatch scales reading 0.5 to 2
// - Update bits 2:0 set ramp base interval
// - Update codes map 100 to 1600 ms
// - Ramp pacing applies in manual mode too
// - Loop off keeps last loop drive level
// - Each interval moves drive at most step
package fan_loop_pkg;

    // ************************************************
    // Register map and fields
    // ************************************************
    localparam logic [7:0] CONFIG_OFFSET = 8'h02;
    localparam logic [7:0] CONFIG_RESET = 8'h2B;
    localparam int LOOP_EN_BIT = 7;
    localparam int RANGE_LSB = 5;
    localparam int EDGES_LSB = 3;
    localparam int UPDATE_LSB = 0;

    // ************************************************
    // Timing
    // ************************************************
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int CYCLES_PER_MS = MS_NS / CLOCK_PERIOD_NS;
    localparam int MS_W = 11;
    localparam int CYC_W = 20;

    // Interval in ms per update code
    localparam logic [10:0] UPDATE_MS [8] = '{
        11'h064, 11'h0C8, 11'h12C, 11'h190,
        11'h1F4, 11'h320, 11'h4B0, 11'h640
    };
    // Minimum reported RPM per range code
    localparam logic [12:0] RANGE_MIN_RPM [4] = '{
        13'h01F4, 13'h03E8, 13'h07D0, 13'h0FA0
    };
    // Tach count multiplier per range code
    localparam logic [3:0] RANGE_MULT [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
    // Minimum edges per rotation per edges code
    localparam logic [3:0] EDGE_COUNT [4] = '{4'h3, 4'h5, 4'h7, 4'h9};
    // Effective multiplier, in halves, per edges code
    localparam logic [2:0] EDGE_MULT_X2 [4] = '{3'h1, 3'h2, 3'h3, 3'h4};

endpackage

// [update_interval_timer.sv]
`timescale 1ns/1ns
module update_interval_timer #(
    parameter int CYCLES_PER_MS = fan_loop_pkg::CYCLES_PER_MS
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [2:0] update_code,
    output logic interval_tick
);
    import fan_loop_pkg::*;

    logic [CYC_W-1:0] cyc_r, cyc_nxt;
    logic [MS_W-1:0] ms_r, ms_nxt;
    logic [2:0] code_r, code_nxt;
    logic ms_end;
    logic iv_end;

    // ************************************************
    // Millisecond and interval counters
    // ************************************************
    // counted interval
    assign ms_end = (cyc_r == CYC_W'(CYCLES_PER_MS - 1));
    assign iv_end = ms_end && (ms_r == UPDATE_MS[code_r] - 11'h001);
    assign interval_tick = ce && iv_end;

    always_comb begin
        cyc_nxt = ms_end ? '0 : cyc_r + CYC_W'(1);
        ms_nxt = ms_r;
        code_nxt = code_r;
        if (ms_end) begin
            ms_nxt = iv_end ? '0 : ms_r + MS_W'(1);
        end
        if (iv_end) begin
            code_nxt = update_code;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            cyc_r <= '0;
            ms_r <= '0;
            code_r <= CONFIG_RESET[2:0];
        end else if (ce) begin
            cyc_r <= cyc_nxt;
            ms_r <= ms_nxt;
            code_r <= code_nxt;
        end
    end

endmodule // update_interval_timer

// [fan_speed_loop_config.sv]
`timescale 1ns/1ns
module fan_speed_loop_config #(
    parameter int CYCLES_PER_MS = fan_loop_pkg::CYCLES_PER_MS
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] drive_setting,
    input wire logic setting_wr,
    input wire logic [7:0] fan_step,
    input wire logic [15:0] tach_target,
    input wire logic [15:0] tach_reading,
    output logic [7:0] fan_drive,
    output logic closed_loop_enable,
    output logic [3:0] tach_count_mult,
    output logic [12:0] min_rpm,
    output logic [3:0] min_edges,
    output logic [2:0] edge_mult_x2,
    output logic interval_tick
);
    import fan_loop_pkg::*;

    logic [7:0] config_r, config_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [7:0] request_r, request_nxt;
    logic [7:0] drive_r, drive_nxt;
    logic [3:0] mult_r, mult_nxt;
    logic [12:0] rpm_r, rpm_nxt;
    logic [3:0] edges_r, edges_nxt;
    logic [2:0] emul_r, emul_nxt;
    logic [1:0] range_code;
    logic [1:0] edge_code;
    logic cfg_hit;
    logic [8:0] up_sum;
    logic [7:0] up_gap;
    logic [7:0] down_gap;

    // ************************************************
    // Configuration register
    // ************************************************
    assign cfg_hit = (reg_addr == CONFIG_OFFSET);
    assign range_code = config_r[RANGE_LSB +: 2];
    assign edge_code = config_r[EDGES_LSB +: 2];

    always_comb begin
        config_nxt = config_r;
        rdata_nxt = rdata_r;
        if (reg_wr && cfg_hit) begin
            config_nxt = reg_wdata;
        end
        if (reg_rd) begin
            rdata_nxt = cfg_hit ? config_r : 8'h00;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            config_r <= CONFIG_RESET;
            rdata_r <= 8'h00;
        end else if (ce) begin
            config_r <= config_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign closed_loop_enable = config_r[LOOP_EN_BIT];

    // ************************************************
    // Tach weighting decode
    // ************************************************
    always_comb begin
        // one range for all tach values
        mult_nxt = RANGE_MULT[range_code];
        rpm_nxt = RANGE_MIN_RPM[range_code];
        edges_nxt = EDGE_COUNT[edge_code];
        emul_nxt = EDGE_MULT_X2[edge_code];
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            mult_r <= RANGE_MULT[CONFIG_RESET[RANGE_LSB +: 2]];
            rpm_r <= RANGE_MIN_RPM[CONFIG_RESET[RANGE_LSB +: 2]];
            edges_r <= EDGE_COUNT[CONFIG_RESET[EDGES_LSB +: 2]];
            emul_r <= EDGE_MULT_X2[CONFIG_RESET[EDGES_LSB +: 2]];
        end else if (ce) begin
            mult_r <= mult_nxt;
            rpm_r <= rpm_nxt;
            edges_r <= edges_nxt;
            emul_r <= emul_nxt;
        end
    end

    assign tach_count_mult = mult_r;
    assign min_rpm = rpm_r;
    assign min_edges = edges_r;
    assign edge_mult_x2 = emul_r;

    // ************************************************
    // Update interval
    // ************************************************
    // update code paces ramp
    update_interval_timer #(
        .CYCLES_PER_MS(CYCLES_PER_MS)
    ) u_timer (
        .clock(clock),
        .nrst(nrst),
        .ce(ce),
        .update_code(config_r[UPDATE_LSB +: 3]),
        .interval_tick(interval_tick)
    );

    // ************************************************
    // Requested level and paced drive
    // ************************************************
    assign up_sum = {1'b0, request_r} + {1'b0, fan_step};
    assign up_gap = request_r - drive_r;
    assign down_gap = drive_r - request_r;

    always_comb begin
        request_nxt = request_r;
        drive_nxt = drive_r;
        if (closed_loop_enable) begin
            if (interval_tick && tach_reading > tach_target) begin
                request_nxt = up_sum[8] ? 8'hFF : up_sum[7:0];
            end else if (interval_tick && tach_reading < tach_target) begin
                request_nxt = (request_r > fan_step) ?
                    request_r - fan_step : 8'h00;
            end
        end else if (setting_wr) begin
            request_nxt = drive_setting;
        end
        if (interval_tick) begin
            if (request_r > drive_r) begin
                drive_nxt = (up_gap > fan_step) ?
                    drive_r + fan_step : request_r;
            end else if (request_r < drive_r) begin
                drive_nxt = (down_gap > fan_step) ?
                    drive_r - fan_step : request_r;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            request_r <= 8'h00;
            drive_r <= 8'h00;
        end else if (ce) begin
            request_r <= request_nxt;
            drive_r <= drive_nxt;
        end
    end

    assign fan_drive = drive_r;

endmodule // fan_speed_loop_config

// [fan_model.sv]
`timescale 1ns/1ns
// ************************************
// Fan with tach output
// ************************************
module fan_model (
    input wire logic [7:0] drive,
    output logic [15:0] tach_count
);
    // More drive, faster fan, smaller count
    always_comb tach_count = 16'h1FFF - {4'h0, drive, 4'h0};
endmodule // fan_model

// [speed_loop_sva.sv]
`timescale 1ns/1ns
module speed_loop_sva #(parameter int CYCLES_PER_MS = 1) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic setting_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] fan_step,
    input wire logic [7:0] fan_drive,
    input wire logic closed_loop_enable,
    input wire logic interval_tick,
    input wire logic [3:0] tach_count_mult,
    input wire logic [3:0] min_edges,
    input wire logic [12:0] min_rpm,
    input wire logic [2:0] edge_mult_x2
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // ************************************
    // Interval gap counter
    // ************************************
    // Wide enough for the longest interval at full clock rate
    logic [31:0] gap_r, gap_nxt;
    wire cfg_wr = ce && reg_wr && reg_addr == 8'h02;
    always_comb gap_nxt = (!nrst || interval_tick) ? 32'h0000_0000
                          : gap_r + {31'h0000_0000, ce};
    always_ff @(posedge clock) gap_r <= gap_nxt;
    sequence wr_s; cfg_wr; endsequence
    sequence hold_s; ce && !cfg_wr; endsequence
    loop_en_a: assert property (
        wr_s |=> closed_loop_enable == $past(reg_wdata[7]))
        else $error("loop enable not taken from write");
    range_dec_a: assert property (wr_s ##1 hold_s |=>
        tach_count_mult == 4'h1 << $past(reg_wdata[6:5], 2) &&
        min_rpm == 13'h01F4 << $past(reg_wdata[6:5], 2))
        else $error("range decode wrong");
    edge_dec_a: assert property (wr_s ##1 hold_s |=>
        min_edges == 4'h3 + {1'b0, $past(reg_wdata[4:3], 2), 1'b0} &&
        edge_mult_x2 == {1'b0, $past(reg_wdata[4:3], 2)} + 3'h1)
        else $error("edges decode wrong");
    rd_back_a: assert property (
        wr_s ##1 (ce && reg_rd && reg_addr == 8'h02)
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("read back differs from write");
    tick_ce_a: assert property (!ce |-> !interval_tick)
        else $error("tick while frozen");
    tick_gap_a: assert property (
        interval_tick |-> gap_r >= 100 * CYCLES_PER_MS - 2)
        else $error("interval too short");
    tick_max_a: assert property (gap_r < 1600 * CYCLES_PER_MS + 2)
        else $error("interval too long");
    drive_pace_a: assert property (
        $past(nrst) && fan_drive != $past(fan_drive) |-> $past(interval_tick))
        else $error("drive moved off tick");
    step_bound_a: assert property (
        $past(nrst) && $past(interval_tick) |->
        (fan_drive > $past(fan_drive) ? fan_drive - $past(fan_drive)
        : $past(fan_drive) - fan_drive) <= $past(fan_step))
        else $error("drive step too large");
endmodule // speed_loop_sva
bind fan_speed_loop_config speed_loop_sva
    #(.CYCLES_PER_MS(CYCLES_PER_MS)) i_sva (.*);

// [tb.sv]
`timescale 1ns/1ns
module tb;
    import fan_loop_pkg::*;
    logic clock, nrst, ce, reg_wr, reg_rd, setting_wr, closed_loop_enable;
    logic interval_tick;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, drive_setting, fan_step;
    logic [7:0] fan_drive, d;
    logic [15:0] tach_target, tach_reading;
    logic [3:0] tach_count_mult, min_edges;
    logic [12:0] min_rpm;
    logic [2:0] edge_mult_x2;
    int fail_count, cmp_count, cycles, gap;
    fan_speed_loop_config #(.CYCLES_PER_MS(1)) i_dut (.*);
    fan_model i_fan (.drive(fan_drive), .tach_count(tach_reading));
    // ************************************
    // Clock, timeout and helpers
    // ************************************
    initial begin
        clock = 0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (fail_count == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(logic [15:0] seen, logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic step(int n = 1);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] v);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1;
        step();
        reg_wr = 0;
        step();
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        reg_addr = a;
        reg_rd = 1;
        step();
        reg_rd = 0;
        step();
        chk(reg_rdata, exp);
    endtask
    task automatic wait_tick();
        for (gap = 0; interval_tick !== 1'b1; gap++) step();
        step();
    endtask
    task automatic set_drive(logic [7:0] v);
        drive_setting = v;
        setting_wr = 1;
        step();
        setting_wr = 0;
    endtask
    initial begin
        {nrst, reg_wr, reg_rd, setting_wr, reg_addr, reg_wdata} = '0;
        {ce, drive_setting, fan_step, tach_target} = {1'b1, 16'h0004, 16'h1000};
        step(12);
        nrst = 1;
        chk(fan_drive, 0);
        chk(tach_count_mult, 2);
        chk(min_edges, 5);
        rd(8'h02, CONFIG_RESET);
        wr(8'h03, 8'hFF);
        rd(8'h03, 8'h00);
        rd(8'h02, CONFIG_RESET);
        reg_wdata = 8'h00;
        reg_wr = 1;
        step();
        reg_wr = 0;
        reg_rd = 1;
        step();
        reg_rd = 0;
        step();
        chk(reg_rdata, 8'h00);
        ce = 0;
        wr(8'h02, 8'hFF);
        step();
        chk(interval_tick, 0);
        chk(closed_loop_enable, 0);
        ce = 1;
        for (int i = 0; i < 4; i++) begin
            wr(8'h02, {1'b0, 2'(i), 2'(i), 3'h0});
            chk(tach_count_mult, 4'h1 << i);
            chk(min_rpm, 13'h01F4 << i);
            chk(min_edges, 16'(3 + 2 * i));
            chk(edge_mult_x2, 16'(i + 1));
        end
        set_drive(8'h0A);
        chk(fan_drive, 0);
        for (int k = 0; k < 3; k++) begin
            wait_tick();
            chk(fan_drive, k < 2 ? 4 * k + 4 : 10);
        end
        wait_tick();
        chk(gap, 99);
        wr(8'h02, 8'hA8);
        chk(closed_loop_enable, 1);
        repeat (3) wait_tick();
        d = fan_drive;
        set_drive(8'h00);
        repeat (2) wait_tick();
        chk(fan_drive > d, 1);
        tach_target = 16'h1FFF;
        d = fan_drive;
        repeat (3) wait_tick();
        chk(fan_drive < d, 1);
        wr(8'h02, 8'h28);
        repeat (2) wait_tick();
        d = fan_drive;
        wait_tick();
        chk(fan_drive, d);
        set_drive(d - 8'h08);
        repeat (2) wait_tick();
        chk(fan_drive, d - 8'h08);
        for (int c = 1; c < 8; c++) begin
            wr(8'h02, {5'h05, 3'(c)});
            wait_tick();
            chk(16'(gap), 16'(UPDATE_MS[c - 1] - 3));
            wait_tick();
            chk(16'(gap), 16'(UPDATE_MS[c] - 1));
        end
        stop_test();
    end
endmodule // tb
